// ===== hw/nibble_xor_defs.vh
`ifndef NIBBLE_XOR_DEFS_VH
`define NIBBLE_XOR_DEFS_VH
`define INSTR_W 14
`define DATA_W 8
`define FADDR_W 7
`define DEST_BIT 7
`define OP_SWAP_HI 6'h0E
`define OP_XORF_HI 6'h06
`define OP_TSTZ_HI 7'h11
`define OP_XORL_HI 6'h1F
`define ACC_RST 8'h00
`define ZFLAG_RST 1'b0
`define FILE_RST 8'h00
`define FILE_DEPTH 128
`endif

// ===== hw/file_reg_mem.v
`timescale 1ns/100ps
`include "nibble_xor_defs.vh"
module file_reg_mem #(
   parameter DW = 8,
   parameter AW = 7,
   parameter DEPTH = 128
) (
   input wire clk_i, // Core clock
   input wire arst_n_i, // Async reset, active low
   input wire [AW-1:0] raddr_i, // Read address
   output reg [DW-1:0] rdata_o, // Registered read data
   input wire we_i, // Write strobe
   input wire [AW-1:0] waddr_i, // Write address
   input wire [DW-1:0] wdata_i // Write data
);
   reg [DW-1:0] mem_r [0:DEPTH-1];
   integer k;
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (k = 0; k < DEPTH; k = k + 1) begin
            mem_r[k] <= `FILE_RST;
         end
         rdata_o <= `FILE_RST;
      end else begin
         if (we_i) begin
            mem_r[waddr_i] <= wdata_i;
         end
         rdata_o <= mem_r[raddr_i];
      end
   end
endmodule // file_reg_mem

// ===== hw/nibble_swap_xor_zero_test_exec.v
`timescale 1ns/100ps
`include "nibble_xor_defs.vh"
module nibble_swap_xor_zero_test_exec #(
   parameter IW = 14,
   parameter DW = 8,
   parameter AW = 7
) (
   input wire clk_i, // Core clock 50 MHz
   input wire arst_n_i, // Async reset, active low
   input wire instr_valid_i, // Instruction word valid
   input wire [IW-1:0] instr_i, // Instruction word
   output reg instr_ready_o, // Ready for next instruction
   output reg [DW-1:0] acc_o, // Working register
   output reg zero_flag_o, // Zero flag
   output reg done_o, // Instruction retired pulse
   output reg illegal_o // Unsupported opcode pulse
);
   localparam S_FETCH = 1'b0;
   localparam S_EXEC = 1'b1;
   localparam OP_NONE = 3'd0;
   localparam OP_SWAP = 3'd1;
   localparam OP_TSTZ = 3'd2;
   localparam OP_XORL = 3'd3;
   localparam OP_XORF = 3'd4;

   // Opcode pattern tests on the upper instruction bits
   function is_swap;
      input [IW-1:0] w;
      begin
         is_swap = (w[13:8] == `OP_SWAP_HI);
      end
   endfunction

   function is_tstz;
      input [IW-1:0] w;
      begin
         is_tstz = (w[13:7] == `OP_TSTZ_HI);
      end
   endfunction

   function is_xorl;
      input [IW-1:0] w;
      begin
         is_xorl = (w[13:8] == `OP_XORL_HI);
      end
   endfunction

   function is_xorf;
      input [IW-1:0] w;
      begin
         is_xorf = (w[13:8] == `OP_XORF_HI);
      end
   endfunction

   function [2:0] decode;
      input [IW-1:0] w;
      begin
         if (is_swap(w))
            decode = OP_SWAP;
         else if (is_tstz(w))
            decode = OP_TSTZ;
         else if (is_xorl(w))
            decode = OP_XORL;
         else if (is_xorf(w))
            decode = OP_XORF;
         else
            decode = OP_NONE;
      end
   endfunction

   // Zero detect shared by the test and both XOR forms
   function is_zero;
      input [DW-1:0] v;
      begin
         is_zero = (v == {DW{1'b0}});
      end
   endfunction

   reg state_r;
   reg state_nxt;
   reg [2:0] op_r;
   reg dest_r;
   reg [AW-1:0] faddr_r;
   reg [DW-1:0] lit_r;
   wire [DW-1:0] fdata;
   reg [DW-1:0] result;
   reg we;
   reg [DW-1:0] acc_nxt;
   reg z_nxt;
   wire take;
   wire [DW-1:0] swap_w;

   file_reg_mem #(
      .DW(DW),
      .AW(AW),
      .DEPTH(`FILE_DEPTH)
   ) u_file (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .raddr_i(instr_i[AW-1:0]),
      .rdata_o(fdata),
      .we_i(we),
      .waddr_i(faddr_r),
      .wdata_i(result)
   );
   // Read is registered at the take edge, so an exec-edge write is seen next

   // Valid is ignored until ready is up, also in the cycle after reset
   assign take = instr_ready_o & instr_valid_i;

   // Each result bit takes the bit half a word away
   genvar g;
   generate
      for (g = 0; g < DW; g = g + 1) begin : g_swap
         assign swap_w[g] = fdata[(g + DW / 2) % DW];
      end
   endgenerate

   // Sequencer: one take cycle, one execute cycle
   always @* begin
      state_nxt = state_r;
      case (state_r)
         S_FETCH: begin
            if (take) begin
               state_nxt = S_EXEC;
            end
         end
         S_EXEC: begin
            state_nxt = S_FETCH;
         end
         default: begin
            state_nxt = S_FETCH;
         end
      endcase
   end

   // Datapath: result, destination and zero flag
   always @* begin
      result = {DW{1'b0}};
      we = 1'b0;
      acc_nxt = acc_o;
      z_nxt = zero_flag_o;
      if (state_r == S_EXEC) begin
         case (op_r)
            OP_SWAP: begin
               result = swap_w;
               if (dest_r) begin
                  we = 1'b1;
               end else begin
                  acc_nxt = result;
               end
            end
            OP_TSTZ: begin
               z_nxt = is_zero(fdata);
            end
            OP_XORL: begin
               result = acc_o ^ lit_r;
               acc_nxt = result;
               z_nxt = is_zero(result);
            end
            OP_XORF: begin
               result = acc_o ^ fdata;
               if (dest_r) begin
                  we = 1'b1;
               end else begin
                  acc_nxt = result;
               end
               z_nxt = is_zero(result);
            end
            default: begin
               result = {DW{1'b0}};
            end
         endcase
      end
   end

   // Sequencer state and handshake outputs
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_r <= S_FETCH;
         instr_ready_o <= 1'b0;
         done_o <= 1'b0;
         illegal_o <= 1'b0;
      end else begin
         state_r <= state_nxt;
         instr_ready_o <= (state_nxt == S_FETCH);
         done_o <= (state_r == S_EXEC);
         illegal_o <= (state_r == S_EXEC) && (op_r == OP_NONE);
      end
   end

   // Instruction fields held through the execute cycle
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         op_r <= OP_NONE;
         dest_r <= 1'b0;
         faddr_r <= {AW{1'b0}};
         lit_r <= {DW{1'b0}};
      end else if (take) begin
         op_r <= decode(instr_i);
         dest_r <= instr_i[`DEST_BIT];
         faddr_r <= instr_i[AW-1:0];
         lit_r <= instr_i[DW-1:0];
      end
   end

   // Working register and zero flag
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         acc_o <= `ACC_RST;
         zero_flag_o <= `ZFLAG_RST;
      end else begin
         acc_o <= acc_nxt;
         zero_flag_o <= z_nxt;
      end
   end
endmodule // nibble_swap_xor_zero_test_exec

// ===== testbench/nibble_exec_chk.sv
`timescale 1ns/100ps
module nibble_exec_chk (
   input wire clk_i, // clk
   input wire arst_n_i, // rst
   input wire instr_valid_i, // valid
   input wire [13:0] instr_i, // word
   input wire instr_ready_o, // ready
   input wire [7:0] acc_o, // acc
   input wire zero_flag_o, // z
   input wire done_o, // done
   input wire illegal_o // bad op
);
   wire tk = instr_valid_i & instr_ready_o;
   wire [6:0] op = instr_i[13:7];
   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   chk_done_two: assert property (tk |=> !instr_ready_o ##1 done_o)
      else $error("done late");
   chk_done_pulse: assert property (done_o |=> !done_o)
      else $error("done long");
   chk_xorl_acc: assert property (tk && op[6:1] == 6'h1f |=> ##1
      acc_o == ($past(acc_o, 2) ^ $past(instr_i[7:0], 2))) else $error("xor literal");
   chk_xorl_zero: assert property (tk && op[6:1] == 6'h1f |=> ##1
      zero_flag_o == (acc_o == 8'h00)) else $error("xor zero");
   chk_swap_keepz: assert property (tk && op[6:1] == 6'h0e |=> ##1 $stable(zero_flag_o))
      else $error("swap flag");
   chk_test_keep: assert property (tk && op == 7'h11 |=> ##1 $stable(acc_o))
      else $error("test acc");
   chk_dest_file: assert property (tk && op[0] && (op[6:1] == 6'h0e || op[6:1] == 6'h06)
      |=> ##1 $stable(acc_o)) else $error("dest file");
   chk_xorf_zero: assert property (tk && op == 7'h0c |=> ##1 zero_flag_o == (acc_o == 8'h00))
      else $error("xor file zero");
   chk_illegal_done: assert property (illegal_o |-> done_o)
      else $error("illegal without done");
   chk_ready_done: assert property (done_o |-> instr_ready_o)
      else $error("not ready after done");
   chk_bad_test: assert property (tk && op == 7'h10 |=> ##1 illegal_o)
      else $error("bad test opcode accepted");
   cover property (tk && op == 7'h11);
   cover property (illegal_o);
   cover property (done_o && zero_flag_o);
endmodule // nibble_exec_chk
bind nibble_swap_xor_zero_test_exec nibble_exec_chk u_chk (.clk_i, .arst_n_i, .instr_valid_i,
   .instr_i, .instr_ready_o, .acc_o, .zero_flag_o, .done_o, .illegal_o);

// ===== testbench/tb.sv
`timescale 1ns/100ps
`define CHK(x, y) begin total_checks++; if ((x) !== (y)) begin fails++; \
   $display("[ERR] %0t %h %h", $time, x, y); end end
module tb;
   reg clk_i = 0, arst_n_i = 0, instr_valid_i = 0;
   reg [13:0] instr_i = 14'h0000;
   wire instr_ready_o, zero_flag_o, done_o, illegal_o;
   wire [7:0] acc_o;
   int fails = 0, total_checks = 0, n;
   logic [31:0] s = 5;
   logic [7:0] m[128], a, f;
   logic [13:0] w;
   logic [6:0] ad;
   logic z, ill;
   logic stop = 0;
   nibble_swap_xor_zero_test_exec u_nibble_swap_xor_zero_test_exec (.clk_i, .arst_n_i,
      .instr_valid_i, .instr_i, .instr_ready_o, .acc_o, .zero_flag_o, .done_o, .illegal_o);
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction
   function automatic logic [7:0] nib(input logic [7:0] v);
      return {v[3:0], v[7:4]};
   endfunction
   task results;
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task run(input logic [13:0] i);
      n = 0;
      while (!stop && instr_ready_o !== 1 && n < 50) begin @(posedge clk_i); #1; n++; end
      if (n >= 50) begin fails++; stop = 1; end
      if (!stop) begin
         instr_i = i;
         instr_valid_i = 1;
         f = m[i[6:0]];
         ill = 0;
         case (i[13:7])
            7'h1c: a = nib(f);
            7'h1d: m[i[6:0]] = nib(f);
            7'h11: z = (f == 0);
            7'h3e, 7'h3f: begin a ^= i[7:0]; z = (a == 0); end
            7'h0c: begin a ^= f; z = (a == 0); end
            7'h0d: begin m[i[6:0]] = a ^ f; z = (m[i[6:0]] == 0); end
            default: ill = 1;
         endcase
         @(posedge clk_i); #1 instr_valid_i = 0;
         n = 0;
         while (done_o !== 1 && n < 5) begin @(posedge clk_i); #1; n++; end
         if (n >= 5) stop = 1;
         `CHK(n, 1)
         `CHK(acc_o, a)
         `CHK(zero_flag_o, z)
         `CHK(illegal_o, ill)
         `CHK(instr_ready_o, 1'b1)
      end
   endtask
   initial begin
      forever #10 clk_i = ~clk_i;
   end
   initial begin
      foreach (m[i]) m[i] = 0;
      a = 0;
      z = 0;
      repeat (5) @(posedge clk_i);
      #1 arst_n_i = 1;
      @(posedge clk_i); #1;
      // Corners: top address, flag set, bad opcode
      run(14'h3f5a); run(14'h06ff); run(14'h0e7f); run(14'h08ff);
      run(14'h0880); run(14'h3fa5); run(14'h0800); run(14'h0eff); run(14'h08ff);
      repeat (400) begin
         s = xs(s);
         ad = s[8] ? 7'h7f : {5'h00, s[13:12]};
         case (s[11:9])
            0: w = {6'h0e, s[7], ad};
            1: w = {7'h11, ad};
            2: w = {6'h1f, s[7:0]};
            4: w = {7'h10, ad};
            default: w = {6'h06, s[7], ad};
         endcase
         run(w);
      end
      results();
   end
endmodule // tb
